/* design/board_reg_pkg.sv */
// Constants, field layouts and carriers for the board register block.
// Assumes a processor bus on pins: chip select, write strobe, offset, 32 data lines.
// Operation
// - During hard reset drive stored config word, unless the flash select bit is active.
// - Config word writable outside hard reset; new value only matters at the next hard reset.
// - Bit 0 picks internal (0) or external (1) arbitration, default 0.
// - Bit 1 picks vector prefix 0xFFF00000 (0) or zero (1), default 0.
// - Bit 3 zero enables boot region zero, one disables it, default 0.
// - Bits 4-5 boot port width: 32, 8, 16 bit, reserved.
// - Bits 7-8 initial space base; default code 10.
// - Bits 9-10 pin function of second card channel; default code 11.
// - Bits 11-12 debug port location: JTAG, none, reserved, card pins.
// - Bits 13-14 external bus clock divider: by one or by two.
// - Reserved bits 2, 6, 15 are stored, read, written and driven like others.
// - Board control register sits at offset 4, read/write, power-on defaults.
// - Board control bits are brought out as outputs for outside logic.
// - Config word register sits at offset 0.
// - Config word loads defaults on power-on reset only, kept over hard reset.
// - Active low flash select bit stops config word driving at hard reset.
package board_reg_pkg;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int ADDR_W = 3;
    localparam int ADDR_SEL_BIT = 2;
    localparam logic [ADDR_W-1:0] CFG_OFFSET = 3'h0;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 3'h4;
    // Register word sits on the upper lines, bit 0 of a field table on line 31
    localparam int WORD_LSB = DATA_W - REG_W;
    localparam logic [REG_W-1:0] LOW_ZERO = 16'h0000;
    localparam logic [REG_W-1:0] ALL_ONES16 = 16'hFFFF;
    localparam logic [DATA_W-1:0] OE_OFF = 32'hFFFFFFFF;
    // Flash configuration select in board control, active low
    localparam int CTRL_FLASH_CFG_BIT = 11;
    // config defaults: space base 10, pin function 11
    localparam logic [REG_W-1:0] CFG_RESET = 16'h0160;
    localparam logic [REG_W-1:0] CTRL_RESET = 16'h39F8;

    localparam logic [1:0] BPW_32 = 2'h0;
    localparam logic [1:0] BPW_8 = 2'h1;
    localparam logic [1:0] BPW_16 = 2'h2;
    localparam logic [1:0] ISB_ZERO = 2'h0;
    localparam logic [1:0] ISB_00F = 2'h1;
    localparam logic [1:0] ISB_FF0 = 2'h2;
    localparam logic [1:0] ISB_FFF = 2'h3;
    localparam logic [1:0] DPF_CARD = 2'h0;
    localparam logic [1:0] DPF_WATCH = 2'h1;
    localparam logic [1:0] DPF_SHOW = 2'h3;
    localparam logic [1:0] DPL_JTAG = 2'h0;
    localparam logic [1:0] DPL_NONE = 2'h1;
    localparam logic [1:0] DPL_CARD = 2'h3;
    localparam logic [1:0] EBD_DIV1 = 2'h0;
    localparam logic [1:0] EBD_DIV2 = 2'h1;

    // Config word in bus order, first field on the top line
    typedef struct packed {
        logic external_arbitration_sel;
        logic vector_prefix_sel;
        logic spare2;
        logic boot_region_disable;
        logic [1:0] boot_port_width;
        logic spare6;
        logic [1:0] initial_space_base;
        logic [1:0] debug_pin_function;
        logic [1:0] debug_port_location;
        logic [1:0] ext_bus_clock_divider;
        logic spare15;
    } reset_cfg_t;

    // Processor bus pins as sampled
    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bus_req_t;

    typedef enum logic {ST_IDLE, ST_BUSY} bus_state_t;
endpackage

/* design/board_register_block.sv */
// Board register block: hard-reset config word and board control register.
// Assumes bus and hard reset pins are asynchronous to clk; sys_rst is power-on reset.
`timescale 1ns/1ns
`default_nettype none
module board_register_block
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire board_reg_pkg::bus_req_t bus_req,
    input wire logic hard_reset_n,
    output logic [board_reg_pkg::DATA_W-1:0] data_out,
    output logic [board_reg_pkg::DATA_W-1:0] data_oe_n,
    output logic xfer_ack_n,
    output logic [board_reg_pkg::REG_W-1:0] board_control,
    output board_reg_pkg::reset_cfg_t reset_config
);
    import board_reg_pkg::*;

    bus_req_t req_s1_ff;
    bus_req_t req_s2_ff;
    logic hr_s1_ff;
    logic hr_s2_ff;
    logic cs_prev_ff;
    bus_state_t st_ff;
    bus_state_t nxt_st;
    logic rd_ff;
    logic nxt_rd;
    reset_cfg_t cfg_ff;
    reset_cfg_t nxt_cfg;
    logic [REG_W-1:0] ctrl_ff;
    logic [REG_W-1:0] nxt_ctrl;
    logic [DATA_W-1:0] out_ff;
    logic [DATA_W-1:0] nxt_out;
    logic [DATA_W-1:0] oe_n_ff;
    logic [DATA_W-1:0] nxt_oe_n;
    logic ack_n_ff;
    logic nxt_ack_n;
    logic hr_active;
    logic drive_cfg;
    logic start;
    logic taken;
    logic sel_ctrl;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] hr_oe_n;

    // Two-stage synchronisers for all pins
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_s1_ff <= '{cs_n: 1'b1, we_n: 1'b1, addr: '0, wdata: '0};
            req_s2_ff <= '{cs_n: 1'b1, we_n: 1'b1, addr: '0, wdata: '0};
            hr_s1_ff <= 1'b1;
            hr_s2_ff <= 1'b1;
            cs_prev_ff <= 1'b1;
        end
        else
        begin
            req_s1_ff <= bus_req;
            req_s2_ff <= req_s1_ff;
            hr_s1_ff <= hard_reset_n;
            hr_s2_ff <= hr_s1_ff;
            cs_prev_ff <= req_s2_ff.cs_n;
        end
    end

    // Access decode on the synchronised pins
    assign hr_active = ~hr_s2_ff;
    // drive only with flash select inactive
    assign drive_cfg = hr_active & ctrl_ff[CTRL_FLASH_CFG_BIT];
    assign start = ~req_s2_ff.cs_n & cs_prev_ff;
    assign taken = (st_ff == ST_IDLE) & start & ~hr_active;
    assign sel_ctrl = req_s2_ff.addr[ADDR_SEL_BIT];

    // Read word, low lines zero
    always_comb
    begin
        if (sel_ctrl)
            rdata = {ctrl_ff, LOW_ZERO};
        else
            rdata = {cfg_ff, LOW_ZERO};
    end

    // Per-line enables for hard-reset driving of the config word
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++)
        begin : g_hr_line
            // every stored bit, spares too, has its line
            if (gi >= WORD_LSB)
                assign hr_oe_n[gi] = ~drive_cfg;
            else
                assign hr_oe_n[gi] = 1'b1;
        end
    endgenerate

    // Bus sequencing and register next values
    always_comb
    begin
        nxt_st = st_ff;
        nxt_rd = rd_ff;
        nxt_cfg = cfg_ff;
        nxt_ctrl = ctrl_ff;
        nxt_out = out_ff;
        nxt_oe_n = OE_OFF;
        nxt_ack_n = 1'b1;
        case (st_ff)
            ST_IDLE:
            begin
                if (taken)
                begin
                    nxt_st = ST_BUSY;
                    nxt_ack_n = 1'b0;
                    nxt_rd = req_s2_ff.we_n;
                    if (!req_s2_ff.we_n)
                    begin
                        if (sel_ctrl)
                            nxt_ctrl = req_s2_ff.wdata[DATA_W-1:WORD_LSB];
                        else
                            nxt_cfg = reset_cfg_t'(req_s2_ff.wdata[DATA_W-1:WORD_LSB]);
                    end
                    else
                    begin
                        // drivers on only while a read answers
                        nxt_out = rdata;
                        nxt_oe_n = '0;
                    end
                end
            end
            ST_BUSY:
            begin
                if (rd_ff && !req_s2_ff.cs_n && !hr_active)
                    nxt_oe_n = '0;
                if (req_s2_ff.cs_n || hr_active)
                begin
                    nxt_st = ST_IDLE;
                    nxt_rd = 1'b0;
                    nxt_oe_n = OE_OFF;
                end
            end
            default:
            begin
                nxt_st = ST_IDLE;
                nxt_rd = 1'b0;
            end
        endcase
        if (hr_active)
        begin
            nxt_out = {cfg_ff, LOW_ZERO};
            nxt_oe_n = hr_oe_n;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff <= ST_IDLE;
            rd_ff <= 1'b0;
            cfg_ff <= reset_cfg_t'(CFG_RESET);
            ctrl_ff <= CTRL_RESET;
            out_ff <= '0;
            oe_n_ff <= OE_OFF;
            ack_n_ff <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
            rd_ff <= nxt_rd;
            cfg_ff <= nxt_cfg;
            ctrl_ff <= nxt_ctrl;
            out_ff <= nxt_out;
            oe_n_ff <= nxt_oe_n;
            ack_n_ff <= nxt_ack_n;
        end
    end

    // Outputs straight from flops
    assign data_out = out_ff;
    assign data_oe_n = oe_n_ff;
    assign xfer_ack_n = ack_n_ff;
    assign board_control = ctrl_ff;
    assign reset_config = cfg_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    chk_hr_drives_cfg: assert property (drive_cfg |=>
        (data_oe_n[DATA_W-1:WORD_LSB] == '0) &&
        (data_out[DATA_W-1:WORD_LSB] == $past(cfg_ff)))
        else $error("config word not driven in hard reset");

    chk_flash_blocks_drive: assert property ((hr_active && !ctrl_ff[CTRL_FLASH_CFG_BIT])
        |=> data_oe_n == OE_OFF)
        else $error("config driven while flash select active");

    chk_cfg_write_lands: assert property ((taken && !req_s2_ff.we_n && !sel_ctrl)
        |=> cfg_ff == $past(req_s2_ff.wdata[DATA_W-1:WORD_LSB]))
        else $error("config write lost");

    chk_cfg_kept_else: assert property (!(taken && !req_s2_ff.we_n && !sel_ctrl)
        |=> $stable(cfg_ff))
        else $error("config word changed without write");

    chk_ctrl_write_lands: assert property ((taken && !req_s2_ff.we_n && sel_ctrl)
        |=> board_control == $past(req_s2_ff.wdata[DATA_W-1:WORD_LSB]))
        else $error("board control write lost");

    chk_read_answer: assert property ((taken && req_s2_ff.we_n)
        |=> (data_oe_n == '0) && (data_out == $past(rdata)) && !xfer_ack_n ##1 xfer_ack_n)
        else $error("read answer wrong");

    chk_idle_tristate: assert property ((st_ff == ST_IDLE && !taken && !hr_active)
        |=> data_oe_n == OE_OFF)
        else $error("drivers on while idle");

    chk_low_lines_zero: assert property ((taken && req_s2_ff.we_n)
        |=> data_out[WORD_LSB-1:0] == LOW_ZERO)
        else $error("low lines not zero on read");

    chk_spares_stored: assert property ((taken && !req_s2_ff.we_n && !sel_ctrl)
        |=> {cfg_ff.spare2, cfg_ff.spare6, cfg_ff.spare15} ==
            {$past(req_s2_ff.wdata[DATA_W-1-2]), $past(req_s2_ff.wdata[DATA_W-1-6]),
             $past(req_s2_ff.wdata[WORD_LSB])})
        else $error("spare bit not stored");

    // Bus refused and registers frozen in hard reset
    // write ack pulse
    chk_write_ack_pulse: assert property ((taken && !req_s2_ff.we_n)
        |=> !xfer_ack_n ##1 xfer_ack_n)
        else $error("write ack not a single pulse");

    chk_hr_no_ack: assert property (hr_active
        |=> xfer_ack_n)
        else $error("access acknowledged during hard reset");

    chk_busy_no_ack: assert property ((st_ff == ST_BUSY)
        |=> xfer_ack_n)
        else $error("second ack within one access");

    chk_hr_keeps_regs: assert property (hr_active
        |=> $stable(cfg_ff) && $stable(ctrl_ff))
        else $error("register changed during hard reset");

    chk_ctrl_kept_else: assert property (!(taken && !req_s2_ff.we_n && sel_ctrl)
        |=> $stable(ctrl_ff))
        else $error("board control changed without write");

    chk_ack_has_cause: assert property (!xfer_ack_n
        |-> $past(taken))
        else $error("ack without a taken access");

    chk_cs_edge_only: assert property ((st_ff == ST_IDLE && !start)
        |=> xfer_ack_n)
        else $error("ack without a select edge");

    chk_read_drive_holds: assert property ((rd_ff && !req_s2_ff.cs_n
        && (st_ff == ST_BUSY) && !hr_active)
        |=> (data_oe_n == '0) && $stable(data_out))
        else $error("read drive dropped early");

    chk_read_release: assert property ((req_s2_ff.cs_n && !hr_active
        && (st_ff == ST_BUSY))
        |=> (data_oe_n == OE_OFF) && (st_ff == ST_IDLE))
        else $error("drivers left on after select release");

    chk_hr_low_undriven: assert property (hr_active
        |=> data_oe_n[WORD_LSB-1:0] == ALL_ONES16)
        else $error("low data lines driven in hard reset");

    // Main scenarios reached
    cov_hr_drive: cover property (drive_cfg ##1 !data_oe_n[DATA_W-1]);
    cov_cfg_write: cover property (taken && !req_s2_ff.we_n && !sel_ctrl);
    cov_ctrl_read: cover property (taken && req_s2_ff.we_n && sel_ctrl);
    cov_flash_cfg: cover property (hr_active && !ctrl_ff[CTRL_FLASH_CFG_BIT]);
    cov_read_release: cover property (st_ff == ST_BUSY && rd_ff && req_s2_ff.cs_n);
endmodule
`default_nettype wire

/* bench/cfg_sampler.sv */
// Processor model: captures the data lines while hard reset is held.
// Assumes the bench resolves line levels with pull-ups on every line.
`timescale 1ns/1ns
`default_nettype none
module cfg_sampler
(
    input wire logic clk,
    input wire logic hard_reset_n,
    input wire logic [31:0] bus_level,
    output logic sample_valid,
    output logic [31:0] sample_word
);
    logic hr_q = 1'b1;
    initial sample_valid = 1'b0;
    initial sample_word = 32'h00000000;

    always @(posedge clk)
    begin
        hr_q <= hard_reset_n;
        sample_valid <= hard_reset_n & ~hr_q;
        if (!hard_reset_n)
            sample_word <= bus_level;
    end
endmodule
`default_nettype wire

/* bench/board_register_block_test.sv */
// Bench for the board register block: bus accesses and hard-reset sampling.
// Assumes a 250 MHz clock and pull-ups on all 32 data lines.
`timescale 1ns/1ns
`default_nettype none
module board_register_block_test;
    import board_reg_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hard_reset_n = 1'b1;
    bus_req_t bus_req = '{cs_n: 1'b1, we_n: 1'b1, addr: 3'h0, wdata: 32'h00000000};
    logic [DATA_W-1:0] data_out;
    logic [DATA_W-1:0] data_oe_n;
    logic xfer_ack_n;
    logic [REG_W-1:0] board_control;
    reset_cfg_t reset_config;
    logic [31:0] bus_level;
    logic sample_valid;
    logic [31:0] sample_word;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h00003BFB;
    logic [31:0] w;
    logic [31:0] c;
    logic rd_pend = 1'b0;
    int n_errors = 0;
    int compares = 0;

    // Clock, 4 ns period
    always #2 clk = ~clk;
    // Undriven lines float high
    assign bus_level = (data_out & ~data_oe_n) | data_oe_n;

    board_register_block u_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
        .hard_reset_n(hard_reset_n), .data_out(data_out), .data_oe_n(data_oe_n),
        .xfer_ack_n(xfer_ack_n), .board_control(board_control), .reset_config(reset_config));
    cfg_sampler u_cpu (.clk(clk), .hard_reset_n(hard_reset_n), .bus_level(bus_level),
        .sample_valid(sample_valid), .sample_word(sample_word));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One bus access, held until acknowledged, then a gap
    task automatic access(input logic rd, input logic [2:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        #1;
        bus_req = '{cs_n: 1'b0, we_n: rd, addr: a, wdata: d};
        rd_pend = rd;
        for (k = 0; k < 12; k++)
        begin
            @(posedge clk);
            if (xfer_ack_n === 1'b0)
                break;
        end
        if (k == 12)
        begin
            n_errors++;
            end_of_test();
        end
        #1;
        bus_req = '{cs_n: 1'b1, we_n: rd, addr: a, wdata: ~d};
        repeat (4) @(posedge clk);
    endtask

    // Hard reset with a write attempt that must be ignored
    task automatic hard_rst(input logic [31:0] exp);
        exp_q.push_back(exp);
        @(posedge clk);
        #1;
        hard_reset_n = 1'b0;
        rd_pend = 1'b0;
        bus_req = '{cs_n: 1'b0, we_n: 1'b0, addr: CFG_OFFSET, wdata: 32'h00000000};
        repeat (6) @(posedge clk);
        #1;
        bus_req.cs_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        hard_reset_n = 1'b1;
        repeat (5) @(posedge clk);
    endtask

    // Compares read data and sampled reset words in order
    always @(posedge clk)
    begin
        if ((xfer_ack_n === 1'b0 && rd_pend) || sample_valid === 1'b1)
            check(sample_valid ? sample_word : bus_level, exp_q.pop_front());
    end

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        exp_q.push_back({16'h0160, 16'h0000});
        access(1'b1, CFG_OFFSET, 32'h00000000);
        exp_q.push_back({16'h39F8, 16'h0000});
        access(1'b1, CTRL_OFFSET, 32'h00000000);
        hard_rst({16'h0160, 16'hFFFF});
        for (int i = 0; i < 8; i++)
        begin
            w = rnd();
            if (i < 4)
                w[31:16] = {8{i[1:0]}};
            c = rnd();
            c[27] = i[0];
            access(1'b0, CFG_OFFSET, w);
            access(1'b0, CTRL_OFFSET, c);
            check({16'h0000, reset_config}, {16'h0000, w[31:16]});
            check({16'h0000, board_control}, {16'h0000, c[31:16]});
            exp_q.push_back({c[31:16], 16'h0000});
            access(1'b1, CTRL_OFFSET, 32'h00000000);
            // new word used at hard reset while flash select bit c[27] is high
            hard_rst(c[27] ? {w[31:16], 16'hFFFF} : 32'hFFFFFFFF);
            exp_q.push_back({w[31:16], 16'h0000});
            access(1'b1, CFG_OFFSET, 32'h00000000);
        end
        check({31'h0, bus_level === 32'hFFFFFFFF}, 32'h00000001);
        end_of_test();
    end
endmodule
`default_nettype wire
